// >>> rtl/spi_frame_sync_consts.svh
// Purpose: Offsets, field positions, reset values for the framing block.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave.
// Notes:   Included by the top module and by the bench.
`ifndef SPI_FRAME_SYNC_CONSTS_SVH
`define SPI_FRAME_SYNC_CONSTS_SVH
// Register byte offsets.
`define OFS_CTRL_ONE_HIGH 5'h00
`define OFS_PORT_CONFIG   5'h04
`define OFS_UNDERRUN_DATA 5'h08
`define OFS_TX_DATA       5'h0C
`define OFS_STATUS        5'h10
// Control field positions.
`define POS_AUDIO_EN      15
`define POS_IGNORE_UR     12
`define POS_MONO          11
`define POS_UR_DATA_EN    10
`define POS_PROTO_LO      8
`define POS_FRAMED        7
`define POS_SYNC_DIR      6
`define POS_POLARITY      5
`define POS_AUTO_SELECT   4
`define POS_PULSE_WIDTH   3
`define POS_WORDS_LO      0
// Fields frozen while the port runs.
`define CTRL_LOCK_MASK    16'h8B00
`define CTRL_RESET        16'h0000
`define PROTO_PCM_DSP     2'h3
// Port configuration fields.
`define POS_PORT_EN       0
`define POS_WLEN_LO       8
`define CFG_RESET         6'h00
`define UR_DATA_RESET     32'h00000000
// Status fields.
`define POS_ST_TX_FULL    0
`define POS_ST_UNDERRUN   1
`define POS_ST_BUSY       2
`endif

// >>> rtl/spi_frame_sync_pkg.sv
// Purpose: Types shared by the framing block.
// Assumes: Nothing beyond the constants header.
// Notes:   One-hot link states.
package spi_frame_sync_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } link_state_e;
endpackage : spi_frame_sync_pkg

// >>> rtl/spi_frame_sync_audio_control.sv
// Purpose: Frame sync, select pin and audio framing of a serial port.
// Assumes: Serial clock comes from outside and is sampled by sys_clk.
// Notes:   Data shifts out MSB first on each falling serial clock edge.
//
// Operation
// - Underrun sends underrun register when enabled and ignored.
// - Non-PCM audio forces word-long sync pulses.
// - Protocol select locked while running; needs audio.
// - Audio enable writable only while port disabled.
// - Mono locked while running; needs audio enable.
// - Direction bit: one receives sync, zero drives.
// - Polarity bit sets sync and select levels.
// - Auto select drives pin during master transfer.
// - Width bit: word-long or one-clock pulse.
// - Count field sets words per sync pulse.
`include "spi_frame_sync_consts.svh"
module spi_frame_sync_audio_control
  import spi_frame_sync_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Avalon-MM slave.
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Serial link.
  input  wire logic        sclkIn,
  output logic             sdoOut,
  // Select pin, also the frame sync pin.
  input  wire logic        selPinIn,
  output logic             selPinOut,
  output logic             selPinOe
);

  ////////////////////////////////////////////////////////////////////////
  // Decodes the count field into the index of the last word of a frame.
  function automatic logic [4:0] last_word(input logic [2:0] code);
    unique case (code)
      3'h0:    last_word = 5'h00;
      3'h1:    last_word = 5'h01;
      3'h2:    last_word = 5'h03;
      3'h3:    last_word = 5'h07;
      3'h4:    last_word = 5'h0F;
      3'h5:    last_word = 5'h1F;
      default: last_word = 5'h00;
    endcase
  endfunction : last_word

  logic [15:0]  ctrl;
  logic [5:0]   cfg;
  logic [31:0]  urData;
  logic [31:0]  txData;
  logic [15:0]  next_ctrl;
  logic [5:0]   next_cfg;
  logic [31:0]  next_urData;
  logic [31:0]  next_txData;
  logic [31:0]  next_rdata;
  logic         next_wait;
  logic         req;
  logic         commit;
  logic         wrTx;
  logic         clrUr;
  link_state_e  state;
  link_state_e  next_state;
  logic         txFull;
  logic         next_txFull;
  logic         urFlag;
  logic         next_urFlag;
  logic [4:0]   bitCnt;
  logic [4:0]   next_bitCnt;
  logic [4:0]   wordCnt;
  logic [4:0]   next_wordCnt;
  logic [31:0]  shiftReg;
  logic [31:0]  next_shift;
  logic [31:0]  holdWord;
  logic [31:0]  next_hold;
  logic         next_sdo;
  logic         next_selOut;
  logic         next_selOe;
  logic         sclkS1;
  logic         sclkS2;
  logic         sclkD;
  logic         syncS1;
  logic         syncS2;

  // Named views of the control fields.
  logic        portEnable;
  logic [4:0]  wlen;
  logic        audioEn;
  logic [1:0]  proto;
  logic        framedEff;
  logic        master;
  logic        pol;
  logic        wideEff;
  logic [4:0]  lastWord;
  logic        urSend;

  assign portEnable = cfg[`POS_PORT_EN];
  assign wlen       = cfg[5:1];
  assign audioEn    = ctrl[`POS_AUDIO_EN];
  assign proto      = audioEn ? ctrl[`POS_PROTO_LO +: 2] : 2'h0;
  // Audio support frames the port even with the framed bit clear.
  assign framedEff  = ctrl[`POS_FRAMED] | audioEn;
  assign master     = ~ctrl[`POS_SYNC_DIR];
  assign pol        = ctrl[`POS_POLARITY];
  // Non-PCM audio ignores the width bit.
  assign wideEff    = ctrl[`POS_PULSE_WIDTH] |
                      (audioEn & (proto != `PROTO_PCM_DSP));
  assign lastWord   = last_word(ctrl[`POS_WORDS_LO +: 3]);
  assign urSend     = ctrl[`POS_IGNORE_UR] & ctrl[`POS_UR_DATA_EN];

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: answers one cycle after a request, then commits.
  always_comb begin
    req         = avs_read | avs_write;
    commit      = avs_write & ~avs_waitrequest;
    next_wait   = ~(req & avs_waitrequest);
    next_rdata  = avs_readdata;
    next_ctrl   = ctrl;
    next_cfg    = cfg;
    next_urData = urData;
    next_txData = txData;
    wrTx        = 1'b0;
    clrUr       = 1'b0;
    if (req && avs_waitrequest) begin
      unique case (avs_address)
        `OFS_CTRL_ONE_HIGH: next_rdata = {16'h0000, ctrl};
        `OFS_PORT_CONFIG:   next_rdata = {19'h0, wlen, 7'h0, portEnable};
        `OFS_UNDERRUN_DATA: next_rdata = urData;
        `OFS_STATUS:        next_rdata = {29'h0, state == ST_SHIFT,
                                          urFlag, txFull};
        default:            next_rdata = 32'h00000000;
      endcase
    end
    if (commit) begin
      unique case (avs_address)
        `OFS_CTRL_ONE_HIGH: begin
          // Locked fields keep their value while the port runs.
          if (portEnable) begin
            next_ctrl = (ctrl & `CTRL_LOCK_MASK) |
                        (avs_writedata[15:0] & ~`CTRL_LOCK_MASK);
          end else begin
            next_ctrl = avs_writedata[15:0];
          end
        end
        `OFS_PORT_CONFIG: begin
          next_cfg = {avs_writedata[`POS_WLEN_LO +: 5],
                      avs_writedata[`POS_PORT_EN]};
        end
        `OFS_UNDERRUN_DATA: next_urData = avs_writedata;
        `OFS_TX_DATA: begin
          next_txData = avs_writedata;
          wrTx        = 1'b1;
        end
        `OFS_STATUS: clrUr = avs_writedata[`POS_ST_UNDERRUN];
        default: ;
      endcase
    end
  end

  // Registers of the bus slave.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl            <= `CTRL_RESET;
      cfg             <= `CFG_RESET;
      urData          <= `UR_DATA_RESET;
      txData          <= 32'h00000000;
      avs_readdata    <= 32'h00000000;
      avs_waitrequest <= 1'b1;
    end else begin
      ctrl            <= next_ctrl;
      cfg             <= next_cfg;
      urData          <= next_urData;
      txData          <= next_txData;
      avs_readdata    <= next_rdata;
      avs_waitrequest <= next_wait;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers plus an edge stage for the serial clock.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclkS1 <= 1'b0;
      sclkS2 <= 1'b0;
      sclkD  <= 1'b0;
      syncS1 <= 1'b0;
      syncS2 <= 1'b0;
    end else begin
      sclkS1 <= sclkIn;
      sclkS2 <= sclkS1;
      sclkD  <= sclkS2;
      syncS1 <= selPinIn;
      syncS2 <= syncS1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link engine: word fetch, shifting, frame counting and pin levels.
  logic        fall;
  logic        go;
  logic        inFrame;
  logic        monoRep;
  logic        consume;
  logic        setUr;
  logic [31:0] word;
  logic [31:0] aligned;

  always_comb begin
    fall         = sclkD & ~sclkS2;
    // A slave waits for a received sync pulse at its active level.
    go           = fall & ((state == ST_SHIFT) | (portEnable &
                   (~framedEff | master | (syncS2 == pol))));
    monoRep      = audioEn & ctrl[`POS_MONO] & wordCnt[0];
    inFrame      = (wordCnt == 5'h00) & (wideEff | (bitCnt == 5'h00));
    if (txFull) begin
      word = txData;
    end else if (urSend) begin
      word = urData;
    end else begin
      word = 32'h00000000;
    end
    if (monoRep) begin
      word = holdWord;
    end
    aligned      = word << (5'd31 - wlen);
    consume      = 1'b0;
    setUr        = 1'b0;
    next_state   = state;
    next_bitCnt  = bitCnt;
    next_wordCnt = wordCnt;
    next_shift   = shiftReg;
    next_hold    = holdWord;
    next_sdo     = sdoOut;
    if (go) begin
      next_state = ST_SHIFT;
      if (bitCnt == 5'h00) begin
        next_hold  = word;
        consume    = txFull & ~monoRep;
        setUr      = ~txFull & ~monoRep;
        next_sdo   = aligned[31];
        next_shift = {aligned[30:0], 1'b0};
      end else begin
        next_sdo   = shiftReg[31];
        next_shift = {shiftReg[30:0], 1'b0};
      end
      if (bitCnt >= wlen) begin
        next_bitCnt  = 5'h00;
        next_wordCnt = (wordCnt >= lastWord) ? 5'h00 :
                       wordCnt + 5'h01;
      end else begin
        next_bitCnt  = bitCnt + 5'h01;
      end
    end
    if (!portEnable) begin
      next_state   = ST_IDLE;
      next_bitCnt  = 5'h00;
      next_wordCnt = 5'h00;
    end
    // Software writes win over consumption and clears lose to events.
    next_txFull  = (txFull & ~consume) | wrTx;
    next_urFlag  = setUr | (urFlag & ~clrUr);
    // Pin ownership and level.
    next_selOe   = portEnable & (framedEff ? master :
                   (master & ctrl[`POS_AUTO_SELECT]));
    if (framedEff) begin
      if (go) begin
        next_selOut = inFrame ? pol : ~pol;
      end else if (state == ST_IDLE) begin
        next_selOut = ~pol;
      end else begin
        next_selOut = selPinOut;
      end
    end else begin
      next_selOut = (state == ST_SHIFT) ? pol : ~pol;
    end
  end

  // Registers of the link engine.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= ST_IDLE;
      txFull    <= 1'b0;
      urFlag    <= 1'b0;
      bitCnt    <= 5'h00;
      wordCnt   <= 5'h00;
      shiftReg  <= 32'h00000000;
      holdWord  <= 32'h00000000;
      sdoOut    <= 1'b0;
      selPinOut <= 1'b1;
      selPinOe  <= 1'b0;
    end else begin
      state     <= next_state;
      txFull    <= next_txFull;
      urFlag    <= next_urFlag;
      bitCnt    <= next_bitCnt;
      wordCnt   <= next_wordCnt;
      shiftReg  <= next_shift;
      holdWord  <= next_hold;
      sdoOut    <= next_sdo;
      selPinOut <= next_selOut;
      selPinOe  <= next_selOe;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks on the framing behaviour.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_ur_data;
    go && bitCnt == 5'h00 && !txFull && !monoRep && urSend
      |=> holdWord == $past(urData);
  endproperty
  a_ur_data: assert property (p_ur_data) else $error("underrun word");

  property p_wide_audio;
    go && framedEff && master && audioEn && proto != `PROTO_PCM_DSP &&
      wordCnt == 5'h00 |=> selPinOut == $past(pol);
  endproperty
  a_wide_audio: assert property (p_wide_audio) else $error("audio width");

  property p_proto_lock;
    commit && avs_address == `OFS_CTRL_ONE_HIGH && portEnable
      |=> ctrl[9:8] == $past(ctrl[9:8]) && ctrl[11] == $past(ctrl[11]);
  endproperty
  a_proto_lock: assert property (p_proto_lock) else $error("lock");

  property p_audio_lock;
    commit && avs_address == `OFS_CTRL_ONE_HIGH && portEnable
      |=> $stable(audioEn);
  endproperty
  a_audio_lock: assert property (p_audio_lock) else $error("audio lock");

  property p_slave_in;
    framedEff && !master |=> !selPinOe;
  endproperty
  a_slave_in: assert property (p_slave_in) else $error("slave drives");

  property p_idle_level;
    state == ST_IDLE && !go && framedEff |=> selPinOut == !$past(pol);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("idle level");

  property p_auto_sel;
    portEnable && !framedEff && master && ctrl[`POS_AUTO_SELECT] &&
      state == ST_SHIFT |=> selPinOe && selPinOut == $past(pol);
  endproperty
  a_auto_sel: assert property (p_auto_sel) else $error("auto select");

  property p_narrow;
    go && framedEff && !wideEff && bitCnt != 5'h00
      |=> selPinOut == !$past(pol);
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow pulse");

  property p_frame_wrap;
    go && portEnable && bitCnt >= wlen && wordCnt >= lastWord
      |=> wordCnt == 5'h00;
  endproperty
  a_frame_wrap: assert property (p_frame_wrap) else $error("frame count");

  property p_port_io;
    !framedEff && !ctrl[`POS_AUTO_SELECT] |=> !selPinOe;
  endproperty
  a_port_io: assert property (p_port_io) else $error("pin owned");

endmodule : spi_frame_sync_audio_control

// >>> tb/serial_link_partner.sv
// Purpose: Far-side serial party for the framing bench.
// Assumes: Its clock idles high and bits launch on the falling edge.
// Notes:   Data and select line are sampled late in each bit.
module serial_link_partner (
  // Link lines.
  output logic        sclkIn,
  input  wire logic   sdoOut,
  input  wire logic   selLine,
  // Sync drive while the block listens.
  output logic        syncDrive,
  output logic        syncLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] dataCap;
  logic [63:0] syncCap;
  ////////////////////////////////////////
  // The clock stands high and the sync wire is released at start.
  initial begin
    sclkIn = 1'h1;
    syncDrive = 1'h0;
    syncLevel = 1'h1;
  end
  // Drives or releases the sync wire in the listening role.
  task set_sync(input logic d, input logic l);
    syncDrive = d;
    syncLevel = l;
  endtask : set_sync
  // Runs n clocks of 800 ns, then stands still between frames.
  task run_clocks(input int n);
    dataCap = 64'h0;
    syncCap = 64'h0;
    #37;
    for (int i = 0; i < n; i++) begin
      sclkIn = 1'h0;
      #400;
      sclkIn = 1'h1;
      #390;
      dataCap = {dataCap[62:0], sdoOut};
      syncCap = {syncCap[62:0], selLine};
      #10;
    end
  endtask : run_clocks
endmodule : serial_link_partner

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for the framing and audio control block.
// Assumes: One wait cycle per bus access; far side in its own module.
// Notes:   The select wire has a pull-up when nobody drives it.
`include "spi_frame_sync_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdData;
  logic        sclkIn, sdoOut, selPinIn, selPinOut, selPinOe, selLine;
  logic        syncDrive, syncLevel;
  int          n_fail, n_compared;
  // The wire: the block if it drives, else the far side, else pull-up.
  assign selLine = selPinOe ? selPinOut : (syncDrive ? syncLevel : 1'h1);
  assign selPinIn = selLine;
  spi_frame_sync_audio_control dut_u (
    .sys_clk         (sys_clk),
    .rst_b           (rst_b),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .sclkIn          (sclkIn),
    .sdoOut          (sdoOut),
    .selPinIn        (selPinIn),
    .selPinOut       (selPinOut),
    .selPinOe        (selPinOe)
  );
  serial_link_partner peer_u (
    .sclkIn    (sclkIn),
    .sdoOut    (sdoOut),
    .selLine   (selLine),
    .syncDrive (syncDrive),
    .syncLevel (syncLevel)
  );
  // The 10 MHz system clock.
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  // Compares one value and counts the outcome.
  task check(input string what, input logic [63:0] seen,
             input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One access, held until waitrequest is sampled low.
  task xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'h0 && k < 40);
    rdData = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    if (avs_waitrequest !== 1'h0) n_fail++;
  endtask : xfer
  // Reads one register and compares it.
  task rd(input logic [4:0] a, input logic [31:0] exp, input string what);
    xfer(1'h0, a, 32'h0);
    check(what, rdData, exp);
  endtask : rd
  // Stops the port, programs it and starts it with word length wl+1.
  task setup(input logic [15:0] ctl, input logic [4:0] wl,
             input logic [31:0] tx);
    xfer(1'h1, `OFS_PORT_CONFIG, 32'h0);
    xfer(1'h1, `OFS_CTRL_ONE_HIGH, {16'h0, ctl});
    xfer(1'h1, `OFS_UNDERRUN_DATA, 32'h123456C3);
    if (tx != 32'h0) xfer(1'h1, `OFS_TX_DATA, tx);
    xfer(1'h1, `OFS_PORT_CONFIG, {19'h0, wl, 8'h01});
  endtask : setup
  task complete_run;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  // Reset value, write locks while running, unmapped address.
  task t_regs;
    rd(`OFS_CTRL_ONE_HIGH, 32'h0, "ctrl reset");
    xfer(1'h1, `OFS_CTRL_ONE_HIGH, 32'hFFFF);
    rd(`OFS_CTRL_ONE_HIGH, 32'hFFFF, "ctrl open");
    xfer(1'h1, `OFS_PORT_CONFIG, 32'h1);
    rd(`OFS_PORT_CONFIG, 32'h1, "cfg back");
    xfer(1'h1, `OFS_CTRL_ONE_HIGH, 32'h0);
    rd(`OFS_CTRL_ONE_HIGH, 32'h8B00, "ctrl lock");
    rd(5'h14, 32'h0, "unmapped");
    xfer(1'h1, `OFS_PORT_CONFIG, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  // Reset with the port stopped returns pin, bus and control to idle.
  task t_reset;
    xfer(1'h1, `OFS_CTRL_ONE_HIGH, 32'h00A8);
    @(posedge sys_clk);
    rst_b <= 1'h0;
    repeat (2) @(posedge sys_clk);
    check("rst oe", selPinOe, 1'h0);
    check("rst sel", selPinOut, 1'h1);
    check("rst wait", avs_waitrequest, 1'h1);
    rst_b <= 1'h1;
    rd(`OFS_CTRL_ONE_HIGH, 32'h0, "rst ctrl");
    $display("t_reset done");
  endtask : t_reset
  // Framed master, one-clock and one-word pulses, no audio.
  task t_master;
    for (int w = 0; w < 2; w++) begin
      setup({12'h00A, w[0], 3'h0}, 5'h07, 32'h9B);
      peer_u.run_clocks(8);
      check("data", peer_u.dataCap, 64'h9B);
      check("sync", peer_u.syncCap, w ? 64'hFF : 64'h80);
      check("drive", selPinOe, 1'h1);
    end
    $display("t_master done");
  endtask : t_master
  // Underrun sends the underrun word only while ignored.
  task t_underrun;
    for (int g = 0; g < 2; g++) begin
      setup({3'h0, g[0], 12'h4A0}, 5'h07, 32'h0);
      peer_u.run_clocks(8);
      check("ur data", peer_u.dataCap, g ? 64'hC3 : 64'h0);
    end
    rd(`OFS_UNDERRUN_DATA, 32'h123456C3, "ur reg");
    $display("t_underrun done");
  endtask : t_underrun
  // Every protocol code with audio on, then mono repeat.
  task t_audio;
    for (int p = 0; p < 4; p++) begin
      setup({6'h20, p[1:0], 8'h21}, 5'h07, 32'h5A);
      peer_u.run_clocks(8);
      check("au data", peer_u.dataCap, 64'h5A);
      check("au sync", peer_u.syncCap, p == 3 ? 64'h80 : 64'hFF);
    end
    setup(16'h8B21, 5'h07, 32'h5A);
    peer_u.run_clocks(16);
    check("mono", peer_u.dataCap, 64'h5A5A);
    $display("t_audio done");
  endtask : t_audio
  // Words per sync pulse for every code, one-bit words.
  task t_count;
    logic [63:0] exp;
    int          n;
    for (int c = 0; c < 8; c++) begin
      n = (c > 5) ? 1 : (1 << c);
      exp = 64'h0;
      for (int i = 0; i < 2 * n; i++) exp = {exp[62:0], (i % n) == 0};
      setup({13'h014, c[2:0]}, 5'h00, 32'h0);
      peer_u.run_clocks(2 * n);
      check("count", peer_u.syncCap, exp);
    end
    $display("t_count done");
  endtask : t_count
  // Listening role: no start until the active-low sync arrives.
  task t_slave;
    peer_u.set_sync(1'h1, 1'h1);
    setup(16'h00C0, 5'h07, 32'h3C);
    rd(`OFS_STATUS, 32'h3, "sticky");
    xfer(1'h1, `OFS_STATUS, 32'h2);
    peer_u.run_clocks(8);
    rd(`OFS_STATUS, 32'h1, "held off");
    peer_u.set_sync(1'h1, 1'h0);
    peer_u.run_clocks(8);
    check("sl data", peer_u.dataCap, 64'h3C);
    check("sl drive", selPinOe, 1'h0);
    rd(`OFS_STATUS, 32'h4, "sl busy");
    peer_u.set_sync(1'h0, 1'h1);
    $display("t_slave done");
  endtask : t_slave
  // Automatic select off and on, active low.
  task t_select;
    for (int m = 0; m < 2; m++) begin
      setup({11'h0, m[0], 4'h0}, 5'h07, 32'hAA);
      peer_u.run_clocks(8);
      check("select", peer_u.syncCap, m ? 64'h0 : 64'hFF);
    end
    $display("t_select done");
  endtask : t_select
  // Reset, then the tests in turn.
  initial begin
    rst_b = 1'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    n_fail = 0;
    n_compared = 0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'h1;
    t_regs();
    t_reset();
    t_master();
    t_underrun();
    t_audio();
    t_count();
    t_slave();
    t_select();
    complete_run();
  end
  // Cuts a hang short well after the expected run time.
  initial begin
    #3000000;
    n_fail++;
    complete_run();
  end
endmodule : tb_top
